// ===== dsbi_exec.v
// Execution unit for decrement-and-skip, unconditional branch and increment opcodes
`timescale 1ns/1ps
`include "dsbi_map.vh"
module dsbi_exec (
    // Clock, reset, enable
    input  wire        i_core_clk,
    input  wire        i_nrst,
    input  wire        i_ce,
    // Instruction in
    input  wire        i_instr_valid,
    input  wire [13:0] i_instr,
    // Operand state
    input  wire [7:0]  i_file_rdata,
    input  wire [7:0]  i_program_counter_page_latch,
    input  wire [12:0] i_pc,
    // File register access
    output wire [6:0]  o_file_addr,
    output wire        o_file_we,
    output wire [7:0]  o_file_wdata,
    // Working register and flag
    output wire        o_w_we,
    output wire [7:0]  o_w_wdata,
    output wire        o_zero_we,
    output wire        o_zero_val,
    // Program counter control
    output wire        o_pc_load,
    output wire [12:0] o_pc_target,
    output wire        o_pc_inc,
    output wire        o_flush,
    output wire        o_executed_nop,
    output wire        o_busy
);
    // One-hot sequencer states
    localparam ST_EXEC  = 2'b01;
    localparam ST_FLUSH = 2'b10;

    // Decrement-and-skip pattern in the six upper bits
    function is_decskip_f;
        input [13:0] word;
        begin
            is_decskip_f = (word[`DSBI_OPC_HI:`DSBI_OPC_LO] == `DSBI_OPC_DECSKIP);
        end
    endfunction

    // Increment pattern in the six upper bits
    function is_inc_f;
        input [13:0] word;
        begin
            is_inc_f = (word[`DSBI_OPC_HI:`DSBI_OPC_LO] == `DSBI_OPC_INC);
        end
    endfunction

    // Branch needs only the three upper bits; the rest is its target
    function is_branch_f;
        input [13:0] word;
        begin
            is_branch_f = (word[`DSBI_BR_HI:`DSBI_BR_LO] == `DSBI_OPC_BRANCH);
        end
    endfunction

    // Destination bit set sends the result back to the file register
    function to_file_f;
        input [13:0] word;
        begin
            to_file_f = (word[`DSBI_DEST_BIT] == `DSBI_DEST_F);
        end
    endfunction

    // Page bits go above the 11-bit immediate to form the 13-bit target
    function [12:0] branch_target_f;
        input [7:0]  page_latch;
        input [13:0] word;
        begin
            branch_target_f = {page_latch[`DSBI_PAGE_HI:`DSBI_PAGE_LO],
                               word[`DSBI_IMM_HI:`DSBI_IMM_LO]};
        end
    endfunction

    // Sequencer
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    // Remembers whether a branch caused the flush, so the second cycle
    // knows not to step the counter past an already loaded target
    reg         flush_by_branch_r;
    reg         flush_by_branch_nxt;
    // Registered outputs
    reg         file_we_r;
    reg         file_we_nxt;
    reg  [7:0]  file_wdata_r;
    reg  [7:0]  file_wdata_nxt;
    reg         w_we_r;
    reg         w_we_nxt;
    reg  [7:0]  w_wdata_r;
    reg  [7:0]  w_wdata_nxt;
    reg         zero_we_r;
    reg         zero_we_nxt;
    reg         zero_val_r;
    reg         zero_val_nxt;
    reg         pc_load_r;
    reg         pc_load_nxt;
    reg  [12:0] pc_target_r;
    reg  [12:0] pc_target_nxt;
    reg         pc_inc_r;
    reg         pc_inc_nxt;
    reg         executed_nop_r;
    reg         executed_nop_nxt;
    // Arithmetic results
    wire [7:0]  alu_res;
    wire        alu_zero;

    // Instruction decode
    wire        is_decskip = is_decskip_f(i_instr);
    wire        is_inc     = is_inc_f(i_instr);
    wire        is_branch  = is_branch_f(i_instr);
    wire        is_file_op = is_decskip || is_inc;
    wire        to_file    = to_file_f(i_instr);
    // Taken only in the execute state, so a word offered during the
    // no-operation cycle is refused rather than queued
    wire        go         = i_ce && i_instr_valid && (state_r == ST_EXEC);

    assign o_file_addr = i_instr[`DSBI_FADDR_HI:`DSBI_FADDR_LO];
    assign o_busy      = (state_r == ST_FLUSH);
    // Flush tells fetch to drop the prefetched word in the same cycle;
    // a registered flush would arrive one word too late
    assign o_flush     = go && ((is_decskip && alu_zero) || is_branch);

    dsbi_alu u_alu (
        .i_operand   (i_file_rdata),
        .i_decrement (is_decskip),
        .o_result    (alu_res),
        .o_zero      (alu_zero)
    );

    always @* begin
        state_nxt           = state_r;
        flush_by_branch_nxt = flush_by_branch_r;
        file_we_nxt         = 1'b0;
        file_wdata_nxt      = file_wdata_r;
        w_we_nxt            = 1'b0;
        w_wdata_nxt         = w_wdata_r;
        zero_we_nxt         = 1'b0;
        zero_val_nxt        = zero_val_r;
        pc_load_nxt         = 1'b0;
        pc_target_nxt       = pc_target_r;
        pc_inc_nxt          = 1'b0;
        executed_nop_nxt    = 1'b0;
        case (state_r)
            ST_EXEC: begin
                if (go && is_file_op) begin
                    file_wdata_nxt = alu_res;
                    w_wdata_nxt    = alu_res;
                    file_we_nxt    = to_file;
                    w_we_nxt       = ~to_file;
                    pc_inc_nxt     = 1'b1;
                    // Decrement-and-skip leaves the zero flag alone
                    if (is_inc) begin
                        zero_we_nxt  = 1'b1;
                        zero_val_nxt = alu_zero;
                    end
                end else if (go && is_branch) begin
                    pc_load_nxt   = 1'b1;
                    pc_target_nxt = branch_target_f(i_program_counter_page_latch,
                                                    i_instr);
                end
                if (o_flush) begin
                    state_nxt           = ST_FLUSH;
                    flush_by_branch_nxt = is_branch;
                end
            end
            ST_FLUSH: begin
                // The discarded word is replaced by a no-operation
                executed_nop_nxt = 1'b1;
                // A skip still steps past the discarded word
                pc_inc_nxt       = ~flush_by_branch_r;
                state_nxt        = ST_EXEC;
            end
            default: begin
                state_nxt = ST_EXEC;
            end
        endcase
    end

    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r           <= ST_EXEC;
            flush_by_branch_r <= 1'b0;
            file_we_r         <= 1'b0;
            file_wdata_r      <= 8'h00;
            w_we_r            <= 1'b0;
            w_wdata_r         <= 8'h00;
            zero_we_r         <= 1'b0;
            zero_val_r        <= 1'b0;
            pc_load_r         <= 1'b0;
            pc_target_r       <= `DSBI_PC_RST;
            pc_inc_r          <= 1'b0;
            executed_nop_r    <= 1'b0;
        end else if (i_ce) begin
            // A low enable freezes everything, so pulses stretch with it
            state_r           <= state_nxt;
            flush_by_branch_r <= flush_by_branch_nxt;
            file_we_r         <= file_we_nxt;
            file_wdata_r      <= file_wdata_nxt;
            w_we_r            <= w_we_nxt;
            w_wdata_r         <= w_wdata_nxt;
            zero_we_r         <= zero_we_nxt;
            zero_val_r        <= zero_val_nxt;
            pc_load_r         <= pc_load_nxt;
            pc_target_r       <= pc_target_nxt;
            pc_inc_r          <= pc_inc_nxt;
            executed_nop_r    <= executed_nop_nxt;
        end
    end

    // Output drive
    assign o_file_we      = file_we_r;
    assign o_file_wdata   = file_wdata_r;
    assign o_w_we         = w_we_r;
    assign o_w_wdata      = w_wdata_r;
    assign o_zero_we      = zero_we_r;
    assign o_zero_val     = zero_val_r;
    assign o_pc_load      = pc_load_r;
    assign o_pc_target    = pc_target_r;
    assign o_pc_inc       = pc_inc_r;
    assign o_executed_nop = executed_nop_r;

    // i_pc kept for observers of the fetch path; unused in this unit's decision
    wire unused_pc = ^i_pc;
endmodule // dsbi_exec

// ===== dsbi_map.vh
// Opcode patterns, field positions and timing constants for the decrement/branch/increment unit
// How it works
// - Decrement-and-skip opcode subtracts one from file register, wrapping modulo 256.
// - Increment opcode adds one to file register, wrapping modulo 256.
// - Destination bit zero writes working register; one writes the file register back.
// - File address is seven bits, 0 to 127; destination is one bit.
// - Zero decrement result discards the already prefetched next instruction.
// - Decrement-and-skip takes one cycle, or two with a no-operation when skipping.
// - Nonzero decrement result continues at the following address.
// - Branch loads PC 10:0 from immediate and PC 12:11 from page latch 4:3.
`ifndef DSBI_MAP_VH
`define DSBI_MAP_VH

`define DSBI_OPC_HI       13
`define DSBI_OPC_LO       8
`define DSBI_OPC_DECSKIP  6'h0b
`define DSBI_OPC_INC      6'h0a
`define DSBI_BR_HI        13
`define DSBI_BR_LO        11
`define DSBI_OPC_BRANCH   3'h5
`define DSBI_DEST_BIT     7
`define DSBI_FADDR_HI     6
`define DSBI_FADDR_LO     0
`define DSBI_IMM_HI       10
`define DSBI_IMM_LO       0
`define DSBI_PAGE_HI      4
`define DSBI_PAGE_LO      3
`define DSBI_DEST_W       1'b0
`define DSBI_DEST_F       1'b1
`define DSBI_NOP_WORD     14'h0000
`define DSBI_PC_RST       13'h0000
`define DSBI_FLUSH_CYCLES 1

`endif

// ===== dsbi_alu.v
// Increment and decrement arithmetic with zero detect
`timescale 1ns/1ps
module dsbi_alu (
    // Operand and control
    input  wire [7:0] i_operand,
    input  wire       i_decrement,
    // Result
    output wire [7:0] o_result,
    output wire       o_zero
);
    // 8-bit sums drop the carry, giving wrap modulo 256
    assign o_result = i_decrement ? (i_operand - 8'h01)
                                  : (i_operand + 8'h01);
    assign o_zero   = (o_result == 8'h00);
endmodule // dsbi_alu

// ===== dsbi_exec_props.sv
// Concurrent checks for the decrement/branch/increment execution unit
`timescale 1ns/1ps
module dsbi_exec_props (
    input wire        i_core_clk, i_nrst, i_ce, i_instr_valid,
    input wire [13:0] i_instr,
    input wire [7:0]  i_file_rdata, i_program_counter_page_latch, o_file_wdata, o_w_wdata,
    input wire        o_file_we, o_w_we, o_zero_we, o_zero_val, o_pc_load, o_pc_inc,
    input wire        o_flush, o_executed_nop, o_busy,
    input wire [12:0] o_pc_target
);
    wire       tk  = i_ce && i_instr_valid && !o_busy;
    wire       dec = tk && i_instr[13:8] == 6'h0b;
    wire       inc = tk && i_instr[13:8] == 6'h0a;
    wire       br  = tk && i_instr[13:11] == 3'h5;
    wire [7:0] res = o_file_we ? o_file_wdata : o_w_wdata;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    AST_DEC_VAL: assert property (dec |=> res == $past(i_file_rdata) - 8'h01)
        else $error("decrement result wrong");
    AST_INC_VAL: assert property (inc |=> res == $past(i_file_rdata) + 8'h01)
        else $error("increment result wrong");
    AST_DEST: assert property ((dec || inc) |=> o_file_we == $past(i_instr[7]))
        else $error("destination select wrong");
    AST_DEST_W: assert property ((dec || inc) |=> o_w_we == !$past(i_instr[7]))
        else $error("working register select wrong");
    AST_SKIP: assert property (dec && i_file_rdata == 8'h01 ##1 i_ce |->
        $past(o_flush) && o_busy && o_pc_inc ##1 o_executed_nop && o_pc_inc)
        else $error("skip sequence wrong");
    AST_NOSKIP: assert property (dec && i_file_rdata != 8'h01 |-> !o_flush
        ##1 o_pc_inc && !o_busy && !o_zero_we)
        else $error("non-skip decrement wrong");
    AST_ZERO: assert property (inc |=> o_zero_we
        && o_zero_val == ($past(i_file_rdata) == 8'hff))
        else $error("zero flag wrong");
    AST_BRANCH: assert property (br ##1 i_ce |-> $past(o_flush) && o_pc_load
        && o_busy && o_pc_target ==
        {$past(i_program_counter_page_latch[4:3]), $past(i_instr[10:0])}
        ##1 o_executed_nop && !o_pc_inc)
        else $error("branch wrong");
    AST_REFUSE: assert property (o_busy && i_ce |=> !o_file_we && !o_w_we && !o_pc_load)
        else $error("op taken while busy");
    AST_FREEZE: assert property (!i_ce |=> $stable(o_file_we) && $stable(o_w_we)
        && $stable(o_pc_inc) && $stable(o_pc_load) && $stable(o_busy) && $stable(o_executed_nop))
        else $error("state moved while clock enable low");
    cover property (dec && i_file_rdata == 8'h01);
    cover property (br);
    cover property (inc && i_instr[7]);
    cover property (o_busy && !i_ce);
endmodule // dsbi_exec_props
bind dsbi_exec dsbi_exec_props dsbi_exec_props_i (.*);

// ===== testbench.sv
// Directed bench for the decrement/branch/increment execution unit
`timescale 1ns/1ps
module testbench;
    reg         i_core_clk = 1'b0;
    reg         i_nrst = 1'b0;
    reg         i_ce = 1'b1;
    reg         i_instr_valid = 1'b0;
    reg  [13:0] i_instr = 14'h0000;
    reg  [7:0]  i_file_rdata = 8'h00;
    reg  [7:0]  i_program_counter_page_latch = 8'hf0;
    reg         fl;
    wire [6:0]  o_file_addr;
    wire        o_file_we, o_w_we, o_zero_we, o_zero_val, o_pc_load, o_pc_inc;
    wire        o_flush, o_executed_nop, o_busy;
    wire [7:0]  o_file_wdata, o_w_wdata;
    wire [12:0] o_pc_target;
    integer     n_errors = 0;
    integer     total_checks = 0;
    always #25 i_core_clk = ~i_core_clk;
    // The current PC is not used by the unit, so it is tied off
    dsbi_exec dsbi_exec_i (
        .i_core_clk                   (i_core_clk),
        .i_nrst                       (i_nrst),
        .i_ce                         (i_ce),
        .i_instr_valid                (i_instr_valid),
        .i_instr                      (i_instr),
        .i_file_rdata                 (i_file_rdata),
        .i_program_counter_page_latch (i_program_counter_page_latch),
        .i_pc                         (13'h0000),
        .o_file_addr                  (o_file_addr),
        .o_file_we                    (o_file_we),
        .o_file_wdata                 (o_file_wdata),
        .o_w_we                       (o_w_we),
        .o_w_wdata                    (o_w_wdata),
        .o_zero_we                    (o_zero_we),
        .o_zero_val                   (o_zero_val),
        .o_pc_load                    (o_pc_load),
        .o_pc_target                  (o_pc_target),
        .o_pc_inc                     (o_pc_inc),
        .o_flush                      (o_flush),
        .o_executed_nop               (o_executed_nop),
        .o_busy                       (o_busy)
    );
    task chk(input [23:0] nm, input [12:0] exp, input [12:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Flush is combinational, so it is sampled before the taking edge
    task op(input v, input [13:0] ins, input [7:0] rd);
        begin
            @(negedge i_core_clk);
            i_instr_valid = v;
            i_instr = ins;
            i_file_rdata = rd;
            #1 fl = o_flush;
            @(posedge i_core_clk);
            #1;
        end
    endtask
    task t_skip;
        begin
            op(1'b1, {6'h0b, 1'b1, 7'h15}, 8'h01);
            chk("fl", 13'h1, fl);
            chk("fwe", 13'h1, o_file_we);
            chk("wd", 13'h0, o_file_wdata);
            chk("bsy", 13'h1, o_busy);
            chk("pci", 13'h1, o_pc_inc);
            chk("zwe", 13'h0, o_zero_we);
            op(1'b1, {6'h0a, 1'b0, 7'h01}, 8'h10);
            chk("fl", 13'h0, fl);
            chk("nop", 13'h1, o_executed_nop);
            chk("wwe", 13'h0, o_w_we);
            chk("pci", 13'h1, o_pc_inc);
            chk("zwe", 13'h0, o_zero_we);
        end
    endtask
    task t_noskip;
        begin
            op(1'b1, {6'h0b, 1'b0, 7'h00}, 8'h00);
            chk("fl", 13'h0, fl);
            chk("wd", 13'h0ff, o_w_wdata);
            chk("inc", 13'h1, o_pc_inc);
            chk("zwe", 13'h0, o_zero_we);
        end
    endtask
    task t_inc;
        begin
            op(1'b1, {6'h0a, 1'b1, 7'h7f}, 8'hff);
            chk("adr", 13'h7f, o_file_addr);
            chk("wd", 13'h0, o_file_wdata);
            chk("fwe", 13'h1, o_file_we);
            chk("zwe", 13'h1, o_zero_we);
            chk("z", 13'h1, o_zero_val);
            op(1'b1, {6'h0a, 1'b0, 7'h02}, 8'h41);
            chk("wd", 13'h42, o_w_wdata);
            chk("wwe", 13'h1, o_w_we);
            chk("z", 13'h0, o_zero_val);
        end
    endtask
    task t_br;
        begin
            op(1'b1, {3'h5, 11'h5a5}, 8'h00);
            chk("fl", 13'h1, fl);
            chk("tgt", 13'h15a5, o_pc_target);
            chk("pld", 13'h1, o_pc_load);
            chk("bsy", 13'h1, o_busy);
            op(1'b0, 14'h0000, 8'h00);
            chk("pci", 13'h0, o_pc_inc);
            chk("nop", 13'h1, o_executed_nop);
            chk("pld", 13'h0, o_pc_load);
            op(1'b0, 14'h0000, 8'h00);
        end
    endtask
    // Clock enable low stretches every state and takes no instruction
    task t_freeze;
        begin
            op(1'b1, {6'h0b, 1'b0, 7'h03}, 8'h01);
            chk("bsy", 13'h1, o_busy);
            @(negedge i_core_clk);
            i_ce = 1'b0;
            i_instr_valid = 1'b0;
            @(posedge i_core_clk);
            #1;
            chk("bsy", 13'h1, o_busy);
            chk("nop", 13'h0, o_executed_nop);
            @(negedge i_core_clk);
            i_ce = 1'b1;
            @(posedge i_core_clk);
            #1;
            chk("nop", 13'h1, o_executed_nop);
            chk("pci", 13'h1, o_pc_inc);
            @(negedge i_core_clk);
            i_ce = 1'b0;
            op(1'b1, {3'h5, 11'h123}, 8'h00);
            chk("fl", 13'h0, fl);
            chk("pld", 13'h0, o_pc_load);
            chk("bsy", 13'h0, o_busy);
            chk("nop", 13'h1, o_executed_nop);
            @(negedge i_core_clk);
            i_ce = 1'b1;
            i_instr_valid = 1'b0;
            @(posedge i_core_clk);
            #1;
            chk("pld", 13'h0, o_pc_load);
            chk("nop", 13'h0, o_executed_nop);
        end
    endtask
    task summarize;
        begin
            if (n_errors == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(negedge i_core_clk);
        i_nrst = 1'b1;
        t_skip;
        t_noskip;
        t_inc;
        t_br;
        t_freeze;
        summarize;
    end
    initial begin
        #20000;
        n_errors = n_errors + 1;
        summarize;
    end
endmodule // testbench
